// File: design/cct_timer_regs.svh
`ifndef CCT_TIMER_REGS_SVH
`define CCT_TIMER_REGS_SVH

// ==========================================================
// register byte offsets
`define CCT_OFF_MODE      8'h00
`define CCT_OFF_FORCE     8'h04
`define CCT_OFF_MMASK     8'h08
`define CCT_OFF_MDATA     8'h0C
`define CCT_OFF_COUNT     8'h10
`define CCT_OFF_SYSCTL    8'h14
`define CCT_OFF_CTRL2     8'h18
`define CCT_OFF_ACTION    8'h1C
`define CCT_OFF_FLAGS     8'h20
`define CCT_OFF_DIR       8'h24
`define CCT_OFF_PORT      8'h28
`define CCT_OFF_PACC      8'h2C
// channel compare values: base + 4 * channel
`define CCT_OFF_CMP_BASE  8'h40

// ==========================================================
// field positions
`define CCT_BIT_TEN       7
`define CCT_BIT_COUNTER_RESET_ON_MASTER_MATCH      3
`define CCT_BIT_PACC_EN   4
`define CCT_BIT_OVF       8

// ==========================================================
// reset values and timing counts
`define CCT_RST_8         8'h00
`define CCT_RST_16        16'h0000
`define CCT_CNT_TOP       16'hFFFF
`define CCT_DIV64_TOP     6'h3F
`define CCT_PRS_MAX_SEL   3'h5

`endif

// File: design/cct_pkg.sv
package cct_pkg;

   // ==========================================================
   // output action codes: mode bit high, level bit low
   typedef enum logic [1:0] {
      CCT_ACT_OFF    = 2'b00,
      CCT_ACT_TOGGLE = 2'b01,
      CCT_ACT_CLEAR  = 2'b10,
      CCT_ACT_SET    = 2'b11
   } cct_act_t;

   // ==========================================================
   // axi response codes
   typedef enum logic [1:0] {
      CCT_RESP_OKAY   = 2'b00,
      CCT_RESP_SLVERR = 2'b10
   } cct_resp_t;

endpackage

// File: design/cct_timer_core.sv
`timescale 1ns/10ps
`include "cct_timer_regs.svh"
// Contract
// - 16-bit prescaled counter, eight channels, pulse accumulator
// - pins are general I/O until function enabled
// - enabled output compare forces pin to output
// - port writes latched while function owns pin
// - mode bit clear capture, set compare
// - force bit performs action without setting flag
// - force register always reads zero
// - master mask forces compare-mode pin to output
// - channel-7 match copies master data to masked bits
// - channel-7 action wins over other channels
// - counter writes only in special mode
// - first count after write may be short
// - enable bit clear stops whole timer
// - divide-by-64 tick comes from prescaler
// - prescale select 1..32, applied at zero stages
// - reset-on-master-match clears counter at channel-7 match
// - action codes disconnect, toggle, clear, set
// - overflow flag on wrap from all ones
module cct_timer_core
   import cct_pkg::*;
#(
   parameter int AW = 8
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          special_mode,
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic [7:0]    tport_in,
   output logic [7:0]         tport_out,
   output logic [7:0]         tport_oe
);

   // ==========================================================
   // functions
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [4:0] pmask(input logic [2:0] sel);
      logic [2:0] s;
      s = (sel > `CCT_PRS_MAX_SEL) ? `CCT_PRS_MAX_SEL : sel;
      return 5'((6'h01 << s) - 6'h01);
   endfunction

   // ==========================================================
   // state
   logic [7:0]  mode_r, mmask_r, mdata_r, dir_r, latch_r, oc_r, oc_nxt;
   logic [7:0]  sysctl_r, ctrl2_r, cflag_r, cflag_nxt;
   logic        ovf_r, ovf_nxt;
   logic [15:0] action_r, cnt_r, cnt_nxt, pacc_r;
   logic [15:0] cmp_r [8];
   logic [5:0]  prs_r;
   logic [2:0]  sel_act_r;
   logic [7:0]  pin_s1_r, pin_s2_r, pin_s3_r;
   logic        aw_v_r, w_v_r, bvalid_r, rvalid_r;
   logic [AW-1:0] aw_a_r;
   logic [31:0] w_d_r, rdata_r, rdata_nxt;
   logic [3:0]  w_s_r;
   logic [1:0]  bresp_r, rresp_r;
   logic        rd_ok;

   // ==========================================================
   // axi write decode
   wire         do_wr    = aw_v_r && w_v_r && !bvalid_r;
   wire [7:0]   wa       = 8'(aw_a_r);
   wire         wa_cmp   = (wa[7:5] == 3'(`CCT_OFF_CMP_BASE >> 5)) && (wa[1:0] == 2'b00);
   wire [2:0]   wa_ch    = wa[4:2];
   wire         wr_mode  = do_wr && (wa == `CCT_OFF_MODE);
   wire         wr_force = do_wr && (wa == `CCT_OFF_FORCE);
   wire         wr_mmask = do_wr && (wa == `CCT_OFF_MMASK);
   wire         wr_mdata = do_wr && (wa == `CCT_OFF_MDATA);
   wire         wr_count = do_wr && (wa == `CCT_OFF_COUNT);
   wire         wr_sys   = do_wr && (wa == `CCT_OFF_SYSCTL);
   wire         wr_ctrl2 = do_wr && (wa == `CCT_OFF_CTRL2);
   wire         wr_act   = do_wr && (wa == `CCT_OFF_ACTION);
   wire         wr_flags = do_wr && (wa == `CCT_OFF_FLAGS);
   wire         wr_dir   = do_wr && (wa == `CCT_OFF_DIR);
   wire         wr_port  = do_wr && (wa == `CCT_OFF_PORT);
   wire         wr_cmp   = do_wr && wa_cmp;
   wire         wr_hit   = wr_mode || wr_force || wr_mmask || wr_mdata || wr_count ||
                           wr_sys || wr_ctrl2 || wr_act || wr_flags || wr_dir ||
                           wr_port || wr_cmp || (do_wr && wa == `CCT_OFF_PACC);
   wire [31:0]  wd_lo    = wmerge(32'h0000_0000, w_d_r, w_s_r);
   wire [31:0]  cnt_mg   = wmerge({16'h0000, cnt_r}, w_d_r, w_s_r);
   wire [31:0]  cmp_mg   = wmerge({16'h0000, cmp_r[wa_ch]}, w_d_r, w_s_r);
   wire [31:0]  act_mg   = wmerge({16'h0000, action_r}, w_d_r, w_s_r);

   // ==========================================================
   // timer core combinational terms
   wire         timer_enable_bit      = sysctl_r[`CCT_BIT_TEN];
   wire         counter_reset_on_master_match     = ctrl2_r[`CCT_BIT_COUNTER_RESET_ON_MASTER_MATCH];
   wire [4:0]   pm       = pmask(sel_act_r);
   wire         tick     = timer_enable_bit && ((prs_r[4:0] & pm) == pm);
   wire         tick64   = timer_enable_bit && (prs_r == `CCT_DIV64_TOP);
   wire [7:0]   force_v  = wr_force ? (wd_lo[7:0] & mode_r) : 8'h00;
   logic [7:0]  match;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         match[i] = tick && mode_r[i] && (cnt_r == cmp_r[i]);
      end
   end
   wire [7:0]   fire     = match | force_v;
   wire         cnt_rst  = match[7] && counter_reset_on_master_match;
   wire         wrap     = tick && !cnt_rst && (cnt_r == `CCT_CNT_TOP);
   wire [7:0]   ic_ev    = ~mode_r & (pin_s2_r ^ pin_s3_r) & {8{timer_enable_bit}};
   logic [7:0]  act_en;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         act_en[i] = (action_r[2*i +: 2] != CCT_ACT_OFF);
      end
   end
   // pin ownership: compare mode and either an action or a channel-7 mask bit
   wire [7:0]   own      = mode_r & (act_en | mmask_r);
   wire [7:0]   port_rd  = ((dir_r | own) & latch_r) | (~(dir_r | own) & pin_s2_r);

   always_comb begin
      oc_nxt = oc_r;
      for (int i = 0; i < 8; i++) begin
         if (fire[i]) begin
            case (cct_act_t'(action_r[2*i +: 2]))
               CCT_ACT_TOGGLE: oc_nxt[i] = ~oc_r[i];
               CCT_ACT_CLEAR:  oc_nxt[i] = 1'b0;
               CCT_ACT_SET:    oc_nxt[i] = 1'b1;
               default:        oc_nxt[i] = oc_r[i];
            endcase
         end
         // channel 7 applied last so it overrides channels 6..0
         if (fire[7] && mmask_r[i]) begin
            oc_nxt[i] = mdata_r[i];
         end
      end
   end

   always_comb begin
      cnt_nxt = cnt_r;
      // write leaves the prescaler alone, so the first interval may be short
      if (wr_count && special_mode) begin
         cnt_nxt = cnt_mg[15:0];
      end else if (tick) begin
         cnt_nxt = cnt_rst ? `CCT_RST_16 : 16'(cnt_r + 16'h0001);
      end
   end

   // set wins over a simultaneous software clear
   always_comb begin
      cflag_nxt = (cflag_r & ~(wr_flags ? wd_lo[7:0] : 8'h00)) | match | ic_ev;
      ovf_nxt   = (ovf_r && !(wr_flags && wd_lo[`CCT_BIT_OVF])) || wrap;
   end

   // ==========================================================
   // pins
   assign tport_oe  = own | dir_r;
   assign tport_out = (own & oc_r) | (~own & latch_r);

   always_ff @(posedge aclk) begin
      pin_s1_r <= tport_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
   end

   // ==========================================================
   // prescaler and counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prs_r     <= 6'h00;
         sel_act_r <= 3'h0;
      end else begin
         if (timer_enable_bit) begin
            prs_r <= 6'(prs_r + 6'h01);
         end
         if (prs_r[4:0] == 5'h00) begin
            sel_act_r <= ctrl2_r[2:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r   <= `CCT_RST_16;
         oc_r    <= `CCT_RST_8;
         cflag_r <= `CCT_RST_8;
         ovf_r   <= 1'b0;
         pacc_r  <= `CCT_RST_16;
      end else begin
         cnt_r   <= cnt_nxt;
         oc_r    <= oc_nxt;
         cflag_r <= cflag_nxt;
         ovf_r   <= ovf_nxt;
         if (tick64 && ctrl2_r[`CCT_BIT_PACC_EN]) begin
            pacc_r <= 16'(pacc_r + 16'h0001);
         end
      end
   end

   always_ff @(posedge aclk) begin
      for (int i = 0; i < 8; i++) begin
         if (!aresetn) begin
            cmp_r[i] <= `CCT_RST_16;
         end else if (wr_cmp && wa_ch == 3'(i) && mode_r[i]) begin
            cmp_r[i] <= cmp_mg[15:0];
         end else if (ic_ev[i]) begin
            cmp_r[i] <= cnt_r;
         end
      end
   end

   // ==========================================================
   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r   <= `CCT_RST_8;
         mmask_r  <= `CCT_RST_8;
         mdata_r  <= `CCT_RST_8;
         sysctl_r <= `CCT_RST_8;
         ctrl2_r  <= `CCT_RST_8;
         action_r <= `CCT_RST_16;
         dir_r    <= `CCT_RST_8;
         latch_r  <= `CCT_RST_8;
      end else begin
         if (wr_mode && w_s_r[0]) begin
            mode_r <= w_d_r[7:0];
         end
         if (wr_mmask && w_s_r[0]) begin
            mmask_r <= w_d_r[7:0];
         end
         if (wr_mdata && w_s_r[0]) begin
            mdata_r <= w_d_r[7:0];
         end
         if (wr_sys && w_s_r[0]) begin
            sysctl_r <= w_d_r[7:0];
         end
         if (wr_ctrl2 && w_s_r[0]) begin
            ctrl2_r <= w_d_r[7:0];
         end
         if (wr_act) begin
            action_r <= act_mg[15:0];
         end
         if (wr_dir && w_s_r[0]) begin
            dir_r <= w_d_r[7:0];
         end
         // latched even for owned pins, driven once the pin is released if its direction bit is set
         if (wr_port && w_s_r[0]) begin
            latch_r <= w_d_r[7:0];
         end
      end
   end

   // ==========================================================
   // axi4-lite write channel
   assign s_axi_awready = !aw_v_r;
   assign s_axi_wready  = !w_v_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_v_r   <= 1'b0;
         w_v_r    <= 1'b0;
         aw_a_r   <= '0;
         w_d_r    <= 32'h0000_0000;
         w_s_r    <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r  <= CCT_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_v_r) begin
            aw_v_r <= 1'b1;
            aw_a_r <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_v_r <= 1'b0;
         end
         if (s_axi_wvalid && !w_v_r) begin
            w_v_r <= 1'b1;
            w_d_r <= s_axi_wdata;
            w_s_r <= s_axi_wstrb;
         end else if (do_wr) begin
            w_v_r <= 1'b0;
         end
         if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (wr_hit && wa[1:0] == 2'b00) ? CCT_RESP_OKAY : CCT_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // axi4-lite read channel
   wire [7:0] ra     = 8'(s_axi_araddr);
   wire       rd_req = s_axi_arvalid && !rvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      rd_ok     = (ra[1:0] == 2'b00);
      if (ra[7:5] == 3'(`CCT_OFF_CMP_BASE >> 5)) begin
         rdata_nxt = {16'h0000, cmp_r[ra[4:2]]};
      end else begin
         case (ra)
            `CCT_OFF_MODE:   rdata_nxt = {24'h00_0000, mode_r};
            `CCT_OFF_FORCE:  rdata_nxt = 32'h0000_0000;
            `CCT_OFF_MMASK:  rdata_nxt = {24'h00_0000, mmask_r};
            `CCT_OFF_MDATA:  rdata_nxt = {24'h00_0000, mdata_r};
            // whole word in one beat keeps both bytes coherent
            `CCT_OFF_COUNT:  rdata_nxt = {16'h0000, cnt_r};
            `CCT_OFF_SYSCTL: rdata_nxt = {24'h00_0000, sysctl_r};
            `CCT_OFF_CTRL2:  rdata_nxt = {24'h00_0000, ctrl2_r};
            `CCT_OFF_ACTION: rdata_nxt = {16'h0000, action_r};
            `CCT_OFF_FLAGS:  rdata_nxt = {23'h00_0000, ovf_r, cflag_r};
            `CCT_OFF_DIR:    rdata_nxt = {24'h00_0000, dir_r};
            `CCT_OFF_PORT:   rdata_nxt = {24'h00_0000, port_rd};
            `CCT_OFF_PACC:   rdata_nxt = {16'h0000, pacc_r};
            default:         rd_ok     = 1'b0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= CCT_RESP_OKAY;
      end else if (rd_req) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_ok ? rdata_nxt : 32'h0000_0000;
         rresp_r  <= rd_ok ? CCT_RESP_OKAY : CCT_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule

// File: verif/cct_timer_core_assertions.sv
`timescale 1ns/10ps
`include "cct_timer_regs.svh"
// ====================
// bus handshake and pin ownership checks
module cct_timer_core_chk
   import cct_pkg::*;
#(
   parameter int AW = 8
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          s_axi_awvalid,
   input  wire logic          s_axi_awready,
   input  wire logic          s_axi_wvalid,
   input  wire logic          s_axi_wready,
   input  wire logic [1:0]    s_axi_bresp,
   input  wire logic          s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [AW-1:0] s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   input  wire logic          s_axi_arready,
   input  wire logic [31:0]   s_axi_rdata,
   input  wire logic [1:0]    s_axi_rresp,
   input  wire logic          s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic [7:0]    tport_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire w_take  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
   a_read_answer: assert property (ar_take |=> s_axi_rvalid)
      else $error("read answer late");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken while answer pending");
   a_write_answer: assert property (w_take && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_force_zero: assert property (
      ar_take && s_axi_araddr == AW'(`CCT_OFF_FORCE) |=> s_axi_rdata == 32'h0000_0000)
      else $error("force register read nonzero");
   a_bad_addr: assert property (ar_take && s_axi_araddr[1:0] != 2'b00
      |=> s_axi_rresp == CCT_RESP_SLVERR) else $error("misaligned read not refused");
   a_oe_by_write: assert property (
      $changed(tport_oe) |-> $rose(s_axi_bvalid)) else $error("enable moved without write");

   c_write: cover property (w_take);
   c_bad_read: cover property (ar_take && s_axi_araddr[1:0] != 2'b00);
   c_oe_move: cover property ($changed(tport_oe));
endmodule

bind cct_timer_core cct_timer_core_chk #(.AW(AW)) u_chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tport_oe
);

// File: verif/capture_compare_timer_core_test.sv
`timescale 1ns/10ps
`include "cct_timer_regs.svh"
module capture_compare_timer_core_test
   import cct_pkg::*;
;
   logic        aclk;
   logic        aresetn;
   logic        special_mode;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic [31:0] wdata;
   logic        wvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        rready;
   logic        awready;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic [7:0]  pins;
   logic [7:0]  tport_out;
   logic [7:0]  tport_oe;
   logic [31:0] d;
   logic [1:0]  r;
   int          mismatches;
   int          num_checks;
   logic [7:0]  rst_addr [9] = '{`CCT_OFF_MODE, `CCT_OFF_MMASK, `CCT_OFF_MDATA,
      `CCT_OFF_COUNT, `CCT_OFF_SYSCTL, `CCT_OFF_CTRL2, `CCT_OFF_ACTION, `CCT_OFF_FLAGS,
      `CCT_OFF_DIR};
   cct_act_t    act_code [4] = '{CCT_ACT_SET, CCT_ACT_CLEAR, CCT_ACT_TOGGLE, CCT_ACT_TOGGLE};
   logic        act_lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   cct_timer_core DUT (
      .aclk(aclk), .aresetn(aresetn), .special_mode(special_mode),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tport_in(pins), .tport_out(tport_out), .tport_oe(tport_oe)
   );

   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // ====================
   // reporting
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic give_up();
      mismatches++;
      $display("unexpected at %0t: bus answer never came", $time);
      print_verdict();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // ====================
   // bus master: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'b00);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      if (n == 64)
         give_up();
      chk({30'd0, bresp}, {30'd0, er}, "write response");
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] rv, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rready <= 1'b0;
      rv = rdata;
      rs = rresp;
      if (n == 64)
         give_up();
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er = 2'b00);
      rd(a, d, r);
      chk(d, ev, "read data");
      chk({30'd0, r}, {30'd0, er}, "read response");
   endtask

   // bounded: a flag that never sets counts one mismatch after 64 reads and the run goes on
   task automatic poll(input logic [7:0] a, input logic [31:0] m);
      int n;
      for (n = 0; n < 64; n++) begin
         rd(a, d, r);
         if ((d & m) != 32'h0000_0000)
            break;
      end
      chk({31'd0, n < 64}, 32'd1, "flag wait");
   endtask

   task automatic pin(input int b, input logic eo, input logic ev);
      @(negedge aclk);
      chk({31'd0, tport_oe[b]}, {31'd0, eo}, "pin enable");
      if (eo)
         chk({31'd0, tport_out[b]}, {31'd0, ev}, "pin level");
   endtask

   // ====================
   // main sequence
   initial begin
      aresetn = 1'b0;
      special_mode = 1'b0;
      pins = 8'h00;
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h0000_0000;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      mismatches = 0;
      num_checks = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rst_addr[i])
         rdc(rst_addr[i], 32'h0000_0000);
      chk({24'd0, tport_oe}, 32'h0000_0000, "idle enables");
      rdc(8'h30, 32'h0000_0000, CCT_RESP_SLVERR);
      rdc(8'h01, 32'h0000_0000, CCT_RESP_SLVERR);
      wr(8'h31, 32'h0000_00FF, CCT_RESP_SLVERR);
      wr(`CCT_OFF_FORCE, 32'h0000_00FF);
      rdc(`CCT_OFF_FORCE, 32'h0000_0000);
      wr(`CCT_OFF_ACTION, 32'h0000_0003);
      pin(0, 1'b0, 1'b0);
      wr(`CCT_OFF_MODE, 32'h0000_0001);
      pin(0, 1'b1, 1'b0);
      foreach (act_code[i]) begin
         wr(`CCT_OFF_ACTION, {30'd0, act_code[i]});
         wr(`CCT_OFF_FORCE, 32'h0000_0001);
         pin(0, 1'b1, act_lvl[i]);
      end
      rdc(`CCT_OFF_FLAGS, 32'h0000_0000);
      wr(`CCT_OFF_ACTION, 32'h0000_0002);
      wr(`CCT_OFF_PORT, 32'h0000_0001);
      pin(0, 1'b1, 1'b0);
      wr(`CCT_OFF_ACTION, 32'h0000_0000);
      pin(0, 1'b0, 1'b0);
      wr(`CCT_OFF_DIR, 32'h0000_0001);
      pin(0, 1'b1, 1'b1);
      wr(`CCT_OFF_MODE, 32'h0000_0003);
      wr(`CCT_OFF_MMASK, 32'h0000_0002);
      pin(1, 1'b1, 1'b0);
      rdc(`CCT_OFF_DIR, 32'h0000_0001);
      wr(`CCT_OFF_MODE, 32'h0000_0001);
      pin(1, 1'b0, 1'b0);
      wr(`CCT_OFF_COUNT, 32'h0000_1234);
      rdc(`CCT_OFF_COUNT, 32'h0000_0000);
      @(posedge aclk);
      special_mode <= 1'b1;
      wr(`CCT_OFF_COUNT, 32'h0000_FFFE);
      rdc(`CCT_OFF_COUNT, 32'h0000_FFFE);
      wr(`CCT_OFF_SYSCTL, 32'h0000_0080);
      poll(`CCT_OFF_FLAGS, 32'h0000_0100);
      wr(`CCT_OFF_SYSCTL, 32'h0000_0000);
      rd(`CCT_OFF_COUNT, d, r);
      repeat (8) @(posedge aclk);
      rdc(`CCT_OFF_COUNT, d);
      // channel 2 clears, channel 7 sets the same pin on the same count
      wr(`CCT_OFF_MODE, 32'h0000_0084);
      wr(`CCT_OFF_MMASK, 32'h0000_0004);
      wr(`CCT_OFF_MDATA, 32'h0000_0004);
      wr(`CCT_OFF_ACTION, 32'h0000_0020);
      wr(`CCT_OFF_CMP_BASE + 8'h08, 32'h0000_0010);
      wr(`CCT_OFF_CMP_BASE + 8'h1C, 32'h0000_0010);
      wr(`CCT_OFF_CTRL2, 32'h0000_0008);
      wr(`CCT_OFF_COUNT, 32'h0000_0000);
      wr(`CCT_OFF_FLAGS, 32'h0000_01FF);
      wr(`CCT_OFF_SYSCTL, 32'h0000_0080);
      poll(`CCT_OFF_FLAGS, 32'h0000_0080);
      pin(2, 1'b1, 1'b1);
      rdc(`CCT_OFF_FLAGS, 32'h0000_0084);
      rd(`CCT_OFF_COUNT, d, r);
      chk({31'd0, d <= 32'h0000_0010}, 32'd1, "count bound");
      // pin 1 edge is captured; port reads latch where driven, pin elsewhere
      @(posedge aclk);
      pins <= 8'h02;
      poll(`CCT_OFF_FLAGS, 32'h0000_0002);
      rd(`CCT_OFF_CMP_BASE + 8'h04, d, r);
      chk({31'd0, d <= 32'h0000_0010}, 32'd1, "capture bound");
      rdc(`CCT_OFF_PORT, 32'h0000_0003);
      // divide by 32: select applies once the running prescaler passes zero
      wr(`CCT_OFF_CTRL2, 32'h0000_0005);
      repeat (40) @(posedge aclk);
      wr(`CCT_OFF_SYSCTL, 32'h0000_0000);
      wr(`CCT_OFF_COUNT, 32'h0000_0000);
      wr(`CCT_OFF_SYSCTL, 32'h0000_0080);
      repeat (320) @(posedge aclk);
      rd(`CCT_OFF_COUNT, d, r);
      chk({31'd0, d >= 32'd9 && d <= 32'd11}, 32'd1, "divide by 32");
      // accumulator ticks only while the prescaler runs
      wr(`CCT_OFF_CTRL2, 32'h0000_0018);
      poll(`CCT_OFF_PACC, 32'h0000_FFFF);
      wr(`CCT_OFF_SYSCTL, 32'h0000_0000);
      rd(`CCT_OFF_PACC, d, r);
      repeat (80) @(posedge aclk);
      rdc(`CCT_OFF_PACC, d);
      print_verdict();
   end
endmodule
